// ==== design/nvm_host.sv ====
// Host controller that drives the asynchronous nonvolatile SRAM pins.
// Assumes pin inputs are synchronous to core_clk and the memory needs no clock.
`timescale 1ns/100ps
`default_nettype none
module nvm_host import nvm_pkg::*; (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // User command port.
    input wire logic cmd_valid,
    input wire nvm_cmd_e cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins.
    output logic chip_en_n,
    output logic write_en_n,
    output logic out_en_n,
    output logic [ADDR_W-1:0] addr_in,
    output logic [DATA_W-1:0] data_io_o,
    output logic data_io_oe,
    input wire logic [DATA_W-1:0] data_io_i,
    output logic hw_store_busy_n_o,
    output logic hw_store_busy_n_oe,
    input wire logic hw_store_busy_n_i
);
    // ==========================================================
    // State
    // ==========================================================
    // Whole controller state held in one packed record.
    typedef struct packed {
        nvm_state_e st;
        nvm_cmd_e op;
        logic [2:0] seq_idx;
        logic [CNT_W-1:0] cnt;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rsp;
        logic ready;
        nvm_pins_s pins;
    } nvm_host_s;

    nvm_host_s cur_q; // Registered state.
    nvm_host_s nxt_d; // Next state.
    logic [ADDR_W-1:0] seq_addr; // Address of the next sequence step.

    // Sequence address table.
    // It looks one step ahead so the next address is set up while the chip is deselected.
    nvm_seq_rom u_rom (
        .idx(cur_q.seq_idx + 3'h1),
        .recall(cur_q.op == NVM_CMD_SW_RECALL),
        .addr(seq_addr)
    );

    // Returns the pins in their idle, deselected form.
    function automatic nvm_pins_s idle_pins(input logic [ADDR_W-1:0] a);
        nvm_pins_s p;
        p.chip_en_n = 1'b1; // Deselected so the device ignores everything else.
        p.write_en_n = 1'b1;
        p.out_en_n = 1'b1;
        p.hw_store_busy_n_o = 1'b1;
        p.hw_store_busy_n_oe = 1'b0; // Line released; the device or a pull-up holds it.
        p.addr_in = a;
        p.data_o = '0;
        p.data_oe = 1'b0;
        return p;
    endfunction

    // Tells whether the command is a software sequence.
    function automatic logic is_seq(input nvm_cmd_e c);
        return (c == NVM_CMD_SW_STORE) || (c == NVM_CMD_SW_RECALL);
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Address is set up one cycle with the chip deselected, then strobed.
    always_comb begin
        nxt_d = cur_q;
        nxt_d.rsp = 1'b0;
        case (cur_q.st)
            NVM_ST_IDLE: begin
                nxt_d.ready = 1'b1;
                if (cmd_valid && cur_q.ready) begin
                    nxt_d.ready = 1'b0;
                    nxt_d.op = cmd_op;
                    nxt_d.wdata = cmd_wdata;
                    // Every sequence starts over from its first address, after any stray access.
                    nxt_d.seq_idx = '0;
                    nxt_d.cnt = '0;
                    if (cmd_op == NVM_CMD_HW_STORE) begin
                        // Pull the busy line low to request a store.
                        nxt_d.pins.hw_store_busy_n_o = 1'b0;
                        nxt_d.pins.hw_store_busy_n_oe = 1'b1;
                        nxt_d.st = NVM_ST_HSTORE;
                    end else begin
                        nxt_d.pins.addr_in = is_seq(cmd_op) ? SEQ_A0 : cmd_addr;
                        nxt_d.st = NVM_ST_SETUP;
                    end
                end
            end
            NVM_ST_SETUP: begin
                // Address is stable now; frame the access with chip-enable.
                nxt_d.pins.chip_en_n = 1'b0;
                nxt_d.pins.hw_store_busy_n_oe = 1'b0;
                if (cur_q.op == NVM_CMD_WRITE) begin
                    // Write-enable falls with chip-enable and output-enable stays high,
                    // so the device never drives the shared data lines.
                    nxt_d.pins.write_en_n = 1'b0;
                    nxt_d.pins.out_en_n = 1'b1;
                    nxt_d.pins.data_o = cur_q.wdata;
                    nxt_d.pins.data_oe = 1'b1;
                end else begin
                    // Every other access is a read; write-enable stays high.
                    nxt_d.pins.write_en_n = 1'b1;
                    nxt_d.pins.out_en_n = 1'b0;
                    nxt_d.pins.data_oe = 1'b0;
                end
                nxt_d.cnt = '0;
                nxt_d.st = NVM_ST_STROBE;
            end
            NVM_ST_STROBE: begin
                if (cur_q.cnt == CNT_W'(ACCESS_CYC - 1)) begin
                    // Sample read data just before the strobe ends.
                    nxt_d.rdata = data_io_i;
                    nxt_d.pins = idle_pins(cur_q.pins.addr_in);
                    nxt_d.cnt = '0;
                    nxt_d.st = NVM_ST_GAP;
                end else begin
                    nxt_d.cnt = cur_q.cnt + CNT_W'(1);
                end
            end
            NVM_ST_GAP: begin
                // Chip stays deselected for the least cycle time gap.
                if (cur_q.cnt == CNT_W'(GAP_CYC - 1)) begin
                    nxt_d.cnt = '0;
                    if (is_seq(cur_q.op) && cur_q.seq_idx != 3'(SEQ_LEN - 1)) begin
                        // Next address of the sequence, strictly in order, no writes between.
                        nxt_d.seq_idx = cur_q.seq_idx + 3'h1;
                        nxt_d.pins.addr_in = seq_addr;
                        nxt_d.st = NVM_ST_SETUP;
                    end else begin
                        // Sixth access floats data, so a sequence returns no data.
                        nxt_d.rsp = 1'b1;
                        nxt_d.st = NVM_ST_IDLE;
                    end
                end else begin
                    nxt_d.cnt = cur_q.cnt + CNT_W'(1);
                end
            end
            NVM_ST_HSTORE: begin
                // Hold the request one cycle past the least pulse width, then release the line
                // and wait until the device lets it rise again. No access is made
                // meanwhile since the device blocks everything until then.
                if (cur_q.cnt != CNT_W'(HSTORE_PULSE_CYC)) begin
                    nxt_d.cnt = cur_q.cnt + CNT_W'(1);
                end else begin
                    nxt_d.pins.hw_store_busy_n_oe = 1'b0;
                    nxt_d.pins.hw_store_busy_n_o = 1'b1;
                    if (!cur_q.pins.hw_store_busy_n_oe && hw_store_busy_n_i) begin
                        // The device stores or skips on its own; the host waits alike for both.
                        nxt_d.rsp = 1'b1;
                        nxt_d.st = NVM_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_d.st = NVM_ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Synchronous reset puts the memory in the deselected state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_q <= '0;
            cur_q.st <= NVM_ST_IDLE;
            cur_q.op <= NVM_CMD_READ;
            cur_q.pins <= idle_pins('0);
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    // ==========================================================
    assign cmd_ready = cur_q.ready;
    assign rsp_valid = cur_q.rsp;
    assign rsp_rdata = cur_q.rdata;
    assign chip_en_n = cur_q.pins.chip_en_n;
    assign write_en_n = cur_q.pins.write_en_n;
    assign out_en_n = cur_q.pins.out_en_n;
    assign addr_in = cur_q.pins.addr_in;
    assign data_io_o = cur_q.pins.data_o;
    assign data_io_oe = cur_q.pins.data_oe;
    assign hw_store_busy_n_o = cur_q.pins.hw_store_busy_n_o;
    assign hw_store_busy_n_oe = cur_q.pins.hw_store_busy_n_oe;
endmodule
`default_nettype wire

// ==== design/nvm_pkg.sv ====
// Package for the host-side controller of an 8K x 8 nonvolatile SRAM.
// Assumes a single 40 MHz clock; all pin timing is counted in its cycles.
package nvm_pkg;
    // ==========================================================
    // Clock and timing
    // ==========================================================
    // Clock period in picoseconds (40 MHz).
    localparam int CLK_PERIOD_PS = 25000;
    // Least access time for the slowest grade, in ns.
    localparam int ACCESS_NS = 55;
    // Access strobe length in cycles, rounded up, at least one.
    localparam int ACCESS_CYC = ((ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ?
        1 : ((ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Least deselect gap between accesses in ns.
    localparam int GAP_NS = 25;
    localparam int GAP_CYC = ((GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ?
        1 : ((GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Least hardware store pulse width in ns.
    localparam int HSTORE_PULSE_NS = 15;
    localparam int HSTORE_PULSE_CYC =
        ((HSTORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ?
        1 : ((HSTORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Width of the strobe counter.
    localparam int CNT_W = 8;

    // ==========================================================
    // Bus widths and sequence addresses
    // ==========================================================
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 13'h0F0F;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;

    // ==========================================================
    // Commands and states
    // ==========================================================
    typedef enum logic [2:0] {
        NVM_CMD_READ, NVM_CMD_WRITE, NVM_CMD_SW_STORE, NVM_CMD_SW_RECALL, NVM_CMD_HW_STORE
    } nvm_cmd_e;

    typedef enum logic [2:0] {
        NVM_ST_IDLE, NVM_ST_SETUP, NVM_ST_STROBE, NVM_ST_GAP, NVM_ST_HSTORE
    } nvm_state_e;

    // Pin bundle toward the memory.
    typedef struct packed {
        logic chip_en_n;
        logic write_en_n;
        logic out_en_n;
        logic hw_store_busy_n_o;
        logic hw_store_busy_n_oe;
        logic [ADDR_W-1:0] addr_in;
        logic [DATA_W-1:0] data_o;
        logic data_oe;
    } nvm_pins_s;
endpackage

// ==== design/nvm_seq_rom.sv ====
// Sequence address lookup for the software store and recall commands.
// Assumes the index stays below the sequence length.
`timescale 1ns/100ps
`default_nettype none
module nvm_seq_rom import nvm_pkg::*; (
    // Selection.
    input wire logic [2:0] idx,
    input wire logic recall,
    // Address out.
    output logic [ADDR_W-1:0] addr
);
    // ==========================================================
    // Lookup
    // ==========================================================
    // Only the last entry differs between store and recall.
    always_comb begin
        case (idx)
            3'h0: addr = SEQ_A0;
            3'h1: addr = SEQ_A1;
            3'h2: addr = SEQ_A2;
            3'h3: addr = SEQ_A3;
            3'h4: addr = SEQ_A4;
            default: addr = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
    end
endmodule
`default_nettype wire

// ==== tb/nvm_dev_model.sv ====
// Behavioural model of the nonvolatile SRAM as seen at its pins.
// Assumes pins change just after core_clk edges; the store line has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module nvm_dev_model import nvm_pkg::*; #(
    parameter int XFER_CYC = 20 // Transfer time, shortened to keep runs short.
) (
    // Sampling clock.
    input wire logic core_clk,
    // Pins from the host.
    input wire logic chip_en_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic busy_line_n,
    // Pins toward the host.
    output logic [DATA_W-1:0] dev_data,
    output logic dev_busy_low
);
    logic [DATA_W-1:0] sram [0:8191];
    logic [DATA_W-1:0] nv [0:8191];
    logic [ADDR_W-1:0] tab [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    int idx = 0;
    int xfer = 0;
    int stores = 0;
    int recalls = 0;
    logic dirty = 1'b0;
    logic we_seen = 1'b0;
    logic ce_q = 1'b1;
    logic hold = 1'b0;
    logic trig;
    logic drive;
    assign dev_busy_low = xfer != 0;
    assign trig = idx == 5 && addr_in inside {SEQ_STORE, SEQ_RECALL};
    // An early write or a transfer keeps the bus floating for the access.
    assign drive = !chip_en_n && !out_en_n && write_en_n && busy_line_n && !dev_busy_low
        && !hold && !trig && !we_seen;
    // A floating bus shows the inverse of its last value, never a stale copy.
    always @(posedge core_clk) begin
        dev_data <= drive ? sram[addr_in] : ~dev_data;
        ce_q <= chip_en_n;
        we_seen <= !chip_en_n && (we_seen || !write_en_n);
        if (dev_busy_low) begin
            xfer <= xfer - 1;
        end else if (!busy_line_n && !hold) begin
            if (dirty) begin
                nv <= sram;
                stores <= stores + 1;
                xfer <= XFER_CYC;
            end
            dirty <= 1'b0;
            hold <= 1'b1;
            idx <= 0;
        end else if (hold) begin
            hold <= !busy_line_n;
        end else if (!chip_en_n && !write_en_n && busy_line_n) begin
            sram[addr_in] <= host_data;
            dirty <= 1'b1;
        end else if (chip_en_n && !ce_q) begin
            // Output enable plays no part in arming.
            if (we_seen) begin
                idx <= 0;
            end else if (idx == 5 && addr_in == SEQ_STORE) begin
                nv <= sram;
                stores <= stores + 1;
                xfer <= XFER_CYC;
                dirty <= 1'b0;
                idx <= 0;
            end else if (idx == 5 && addr_in == SEQ_RECALL) begin
                sram <= nv;
                recalls <= recalls + 1;
                xfer <= XFER_CYC;
                dirty <= 1'b0;
                idx <= 0;
            end else begin
                idx <= (idx < 5 && addr_in == tab[idx]) ? idx + 1 : int'(addr_in == SEQ_A0);
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/nvm_host_sva.sv ====
// Checker for the pins and command port of the nonvolatile SRAM host.
// Assumes it is bound to nvm_host and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module nvm_host_chk import nvm_pkg::*; (
    // Clock, reset and command port.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire nvm_cmd_e cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    // Memory pins.
    input wire logic chip_en_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic data_io_oe,
    input wire logic hw_store_busy_n_oe
);
    // ==========================================================
    // Software sequence tracking
    // ==========================================================
    logic sw_q; // High from a taken software command until its response.
    logic take; // A command is accepted at this edge.
    assign take = cmd_valid && cmd_ready;
    // Cleared by the response, so back-to-back commands re-arm cleanly.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_q <= 1'b0;
        end else if (take) begin
            sw_q <= cmd_op inside {NVM_CMD_SW_STORE, NVM_CMD_SW_RECALL};
        end else if (rsp_valid) begin
            sw_q <= 1'b0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_read_we_high: assert property (!chip_en_n && !out_en_n |-> write_en_n)
        else $error("read strobe with write enable low");
    a_ce_busy_off: assert property (!chip_en_n |-> !hw_store_busy_n_oe)
        else $error("store line pulled during an access");
    a_write_data: assert property (!chip_en_n && !write_en_n |-> data_io_oe)
        else $error("write strobe without driven data");
    a_seq_first: assert property (take && cmd_op == NVM_CMD_SW_STORE |->
        ##[1:3] (!chip_en_n && addr_in == SEQ_A0) ##[1:8] (!chip_en_n && addr_in == SEQ_A1))
        else $error("sequence does not open with its first two addresses");
    a_seq_last: assert property (take && cmd_op == NVM_CMD_SW_RECALL |->
        ##[20:40] (!chip_en_n && addr_in == SEQ_RECALL))
        else $error("recall sequence does not end on its address");
    a_seq_we_high: assert property (sw_q && !chip_en_n |-> write_en_n)
        else $error("write strobe inside a sequence");
    a_seq_no_drive: assert property (sw_q |-> !data_io_oe)
        else $error("data driven inside a sequence");
    a_read_answer: assert property (take && cmd_op == NVM_CMD_READ |-> ##[6:7] rsp_valid)
        else $error("read response late");
endmodule
bind nvm_host nvm_host_chk u_chk (.core_clk, .rst, .cmd_valid, .cmd_op, .cmd_ready,
    .rsp_valid, .chip_en_n, .write_en_n, .out_en_n, .addr_in, .data_io_oe, .hw_store_busy_n_oe);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the memory model and checker files are compiled beside it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module testbench import nvm_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    nvm_cmd_e cmd_op = NVM_CMD_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic cmd_ready, rsp_valid, chip_en_n, write_en_n, out_en_n, data_io_oe;
    logic busy_o, busy_oe, dev_busy_low, busy_line_n;
    logic [DATA_W-1:0] rsp_rdata, data_io_o, dev_data;
    logic [ADDR_W-1:0] addr_in;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    // Wired line: low while either side pulls, otherwise held up.
    assign busy_line_n = !(busy_oe && !busy_o) && !dev_busy_low;
    nvm_host u_dut (.core_clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready,
        .rsp_valid, .rsp_rdata, .chip_en_n, .write_en_n, .out_en_n, .addr_in, .data_io_o,
        .data_io_oe, .data_io_i(dev_data), .hw_store_busy_n_o(busy_o),
        .hw_store_busy_n_oe(busy_oe), .hw_store_busy_n_i(busy_line_n));
    nvm_dev_model u_mem (.core_clk, .chip_en_n, .write_en_n, .out_en_n, .addr_in,
        .host_data(data_io_o), .busy_line_n, .dev_data, .dev_busy_low);
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Holds the request until it is taken, then waits for the response.
    task automatic run(input nvm_cmd_e op, input logic [12:0] a, input logic [7:0] d);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin @(posedge core_clk); #1; end
        @(posedge core_clk); #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) begin @(posedge core_clk); #1; end
    endtask
    task automatic t_rw;
        for (int i = 0; i < 4; i++) run(NVM_CMD_WRITE, 13'h1FFF - 13'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < 4; i++) begin
            run(NVM_CMD_READ, 13'h1FFF - 13'(i), 8'h00);
            `CHK("rdata", 8'hA0 + 8'(i), rsp_rdata)
        end
        $display("test t_rw done");
    endtask
    task automatic t_sw;
        run(NVM_CMD_WRITE, 13'h0200, 8'h5A);
        run(NVM_CMD_SW_STORE, 13'h0000, 8'h00);
        repeat (30) @(posedge core_clk);
        `CHK("stores", 1, u_mem.stores)
        run(NVM_CMD_WRITE, 13'h0200, 8'hC3);
        run(NVM_CMD_SW_RECALL, 13'h0000, 8'h00);
        repeat (30) @(posedge core_clk);
        `CHK("recalls", 1, u_mem.recalls)
        run(NVM_CMD_READ, 13'h0200, 8'h00);
        `CHK("recalled", 8'h5A, rsp_rdata)
        $display("test t_sw done");
    endtask
    task automatic t_hw;
        run(NVM_CMD_WRITE, 13'h0300, 8'h11);
        run(NVM_CMD_HW_STORE, 13'h0000, 8'h00);
        `CHK("hw store", 2, u_mem.stores)
        `CHK("line high", 1'b1, busy_line_n)
        run(NVM_CMD_HW_STORE, 13'h0000, 8'h00);
        `CHK("skipped", 2, u_mem.stores)
        $display("test t_hw done");
    endtask
    // A stray address mid-sequence must restart detection.
    task automatic t_break;
        logic [12:0] seq [0:6] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h0123, 13'h1FFF,
            13'h10F0, 13'h0F0F};
        foreach (seq[i]) run(NVM_CMD_READ, seq[i], 8'h00);
        repeat (30) @(posedge core_clk);
        `CHK("no store", 2, u_mem.stores)
        $display("test t_break done");
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_rw();
        t_sw();
        t_hw();
        t_break();
        report_and_stop();
    end
endmodule
`default_nettype wire
